//--- include/swm_pkg.sv
// Purpose: constants and types for the single-wire bus master
// Assumes: 200 MHz system clock, 1 us tick from a divider
// Notes: all link timing is counted in 1 us ticks
package swm_pkg;
  localparam int unsigned CLK_MHZ = 200;          // System clock rate in MHz
  localparam int unsigned TICK_DIV = CLK_MHZ;     // Cycles per microsecond tick
  // Link timing in microseconds
  localparam int unsigned T_RSTL_US = 480;        // Reset low, least
  localparam int unsigned T_PRES_WAIT_US = 70;    // Presence sample point after release
  localparam int unsigned T_RST_REST_US = 410;    // Remainder of receive window
  localparam int unsigned T_SLOT_US = 65;         // Whole slot, kept above 60
  localparam int unsigned T_LOW1_US = 6;          // Write-one low time; read slots use T_READ_INIT_US
  localparam int unsigned T_READ_INIT_US = 2;     // Read slot low time, above 1
  localparam int unsigned T_READ_SAMPLE_US = 13;  // Read sample point, below 15
  localparam int unsigned T_REC_US = 3;           // Recovery between slots, above 1
  localparam logic [9:0] RESET_VAL_CNT = 10'h000; // Counter value after wrap
  // Host command kinds
  typedef enum logic [1:0] {
    SWM_OP_RESET,
    SWM_OP_WRITE,
    SWM_OP_READ
  } swm_op_t;
  // Function commands seen by the device
  localparam logic [7:0] CMD_CONVERT = 8'h44;
  localparam logic [7:0] CMD_READ_PAD = 8'hbe;
  localparam logic [7:0] CMD_WRITE_PAD = 8'h4e;
  localparam logic [7:0] CMD_WRITE_USER = 8'h66;
  localparam logic [7:0] CMD_COPY_PAD = 8'h48;
  localparam logic [7:0] CMD_NVM_RELOAD = 8'hb8;
  localparam logic [7:0] CMD_READ_SUPPLY = 8'hb4;
endpackage

//--- src/swm_tick.sv
// Purpose: one-cycle microsecond enable pulse
// Assumes: single clock, synchronous reset
// Notes: free running, restarted only by reset
`timescale 1ns/1ps
module swm_tick #(
  parameter int unsigned DIV = swm_pkg::TICK_DIV
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Enable out
  output logic tick
);
  import swm_pkg::*;
  initial begin
    if (DIV < 2 || DIV > 1023) $error("swm_tick: DIV out of range");
  end
  typedef struct packed {
    logic [9:0] cnt; // Cycle counter
    logic tick;      // Registered pulse
  } swm_tick_st_t;
  swm_tick_st_t s_q, s_d;
  // Next state: count up and pulse at wrap
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == 10'(DIV - 1)) begin
      s_d.cnt = RESET_VAL_CNT;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 10'h001;
    end
  end
  // State register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign tick = s_q.tick;
endmodule // swm_tick

//--- src/swm_master.sv
// Purpose: bus master for a single-wire temperature sensor link
// Assumes: open-drain data line with external pull-up; timing in 1 us ticks
// Notes: byte-level engine; the caller sequences ROM and function commands
`timescale 1ns/1ps
module swm_master
  import swm_pkg::*;
#(
  parameter int unsigned DIV = swm_pkg::TICK_DIV
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire swm_pkg::swm_op_t cmd_op,
  input wire logic [3:0] cmd_bits,
  input wire logic [7:0] cmd_data,
  // Answer port
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_presence,
  // Line pins
  input wire logic line_in,
  output logic line_out,
  output logic line_oe
);
  import swm_pkg::*;
  initial begin
    if (DIV < 2 || DIV > 1023) $error("swm_master: DIV out of range");
  end
  typedef enum {
    ST_IDLE,
    ST_RST_LOW,
    ST_RST_WAIT,
    ST_RST_REST,
    ST_SLOT_LOW,
    ST_SLOT_HOLD,
    ST_RECOVER,
    ST_DONE
  } swm_state_t;
  typedef struct packed {
    swm_state_t st;      // Sequencer state
    logic [9:0] us;      // Microsecond counter inside a phase
    logic [7:0] shreg;   // Byte being moved, LSB on the line first
    logic [3:0] left;    // Slots left in this command
    logic [3:0] total;   // Slots in this command
    logic rd;            // Current command is a read
    logic drive;         // Master pulls the line low
    logic pres;          // Presence seen
    logic rvalid;        // Answer pulse
    logic [7:0] rdata;   // Answer byte
    logic sync1;         // First synchroniser stage
    logic sync2;         // Second synchroniser stage
  } swm_st_t;
  swm_st_t s_q, s_d;
  logic tick;
  // Microsecond enable
  swm_tick #(.DIV(DIV)) u_tick (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tick)
  );
  // Low time of the current slot; zero bit holds the full slot
  function automatic logic [9:0] low_time(input logic rd, input logic bitv);
    if (rd) begin
      low_time = 10'(T_READ_INIT_US);
    end else if (bitv) begin
      low_time = 10'(T_LOW1_US);
    end else begin
      low_time = 10'(T_SLOT_US);
    end
  endfunction
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.sync1 = line_in;
    s_d.sync2 = s_q.sync1;
    case (s_q.st)
      ST_IDLE: begin
        // One command at a time, in the order given; a reset waits for the byte in flight
        if (cmd_valid) begin
          s_d.us = '0;
          s_d.pres = 1'b0;
          // A reset is taken at once and abandons nothing in flight here
          if (cmd_op == SWM_OP_RESET) begin
            s_d.st = ST_RST_LOW;
            s_d.drive = 1'b1;
          end else begin
            s_d.rd = (cmd_op == SWM_OP_READ);
            s_d.shreg = (cmd_op == SWM_OP_READ) ? 8'hff : cmd_data;
            s_d.total = (cmd_bits == 4'h0 || cmd_bits > 4'h8) ? 4'h8 : cmd_bits;
            s_d.left = s_d.total;
            s_d.st = ST_SLOT_LOW;
            s_d.drive = 1'b1;
          end
        end
      end
      ST_RST_LOW: begin
        if (tick) begin
          s_d.us = s_q.us + 10'h001;
          // The first tick may come one cycle after the take, so one extra tick keeps the full low time
          if (s_q.us == 10'(T_RSTL_US)) begin
            s_d.drive = 1'b0;
            s_d.us = '0;
            s_d.st = ST_RST_WAIT;
          end
        end
      end
      ST_RST_WAIT: begin
        // Sample after the longest wait, inside the least presence low
        if (tick) begin
          s_d.us = s_q.us + 10'h001;
          if (s_q.us == 10'(T_PRES_WAIT_US - 1)) begin
            s_d.pres = ~s_q.sync2;
            s_d.us = '0;
            s_d.st = ST_RST_REST;
          end
        end
      end
      ST_RST_REST: begin
        // Wait out the rest of the receive window before the next slot
        if (tick) begin
          s_d.us = s_q.us + 10'h001;
          if (s_q.us == 10'(T_RST_REST_US - 1)) begin
            s_d.rdata = 8'h00;
            s_d.st = ST_DONE;
          end
        end
      end
      ST_SLOT_LOW: begin
        if (tick) begin
          s_d.us = s_q.us + 10'h001;
          if (s_q.us == low_time(s_q.rd, s_q.shreg[0]) - 10'h001) begin
            s_d.drive = 1'b0;
            s_d.st = ST_SLOT_HOLD;
          end
        end
      end
      ST_SLOT_HOLD: begin
        if (tick) begin
          s_d.us = s_q.us + 10'h001;
          // Late sample point keeps margin for the slow pull-up rise
          if (s_q.rd && s_q.us == 10'(T_READ_SAMPLE_US - 1)) begin
            s_d.shreg = {s_q.sync2, s_q.shreg[7:1]};
          end
          if (s_q.us >= 10'(T_SLOT_US - 1)) begin
            s_d.us = '0;
            s_d.st = ST_RECOVER;
          end
        end
      end
      ST_RECOVER: begin
        if (tick) begin
          s_d.us = s_q.us + 10'h001;
          if (s_q.us == 10'(T_REC_US - 1)) begin
            s_d.us = '0;
            s_d.left = s_q.left - 4'h1;
            if (s_q.left == 4'h1) begin
              // Right-align a short read so the first bit lands in bit 0
              s_d.rdata = s_q.shreg >> (4'h8 - s_q.total);
              s_d.st = ST_DONE;
            end else begin
              if (!s_q.rd) begin
                s_d.shreg = {1'b0, s_q.shreg[7:1]};
              end
              s_d.drive = 1'b1;
              s_d.st = ST_SLOT_LOW;
            end
          end
        end
      end
      ST_DONE: begin
        s_d.rvalid = 1'b1;
        s_d.st = ST_IDLE;
      end
      default: begin
        s_d.st = ST_IDLE;
        s_d.drive = 1'b0;
      end
    endcase
  end
  // State register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '{st: ST_IDLE, sync1: 1'b1, sync2: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end
  // Outputs; line is open drain, so out is always low
  assign cmd_ready = (s_q.st == ST_IDLE);
  assign rsp_valid = s_q.rvalid;
  assign rsp_data = s_q.rdata;
  assign rsp_presence = s_q.pres;
  assign line_out = 1'b0;
  assign line_oe = s_q.drive;
endmodule // swm_master

//--- testbench/swm_chk.sv
// Purpose: port checks for the single-wire master
// Assumes: DIV cycles per microsecond tick
// Notes: run lengths of line_oe are counted in cycles
`timescale 1ns/1ps
module swm_chk
  import swm_pkg::*;
#(
  parameter int unsigned DIV = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Command side
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire swm_pkg::swm_op_t cmd_op,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_presence,
  // Line
  input wire logic line_out,
  input wire logic line_oe
);
  logic [31:0] lo_q; // Cycles pulled low
  logic [31:0] hi_q; // Cycles released, saturates
  swm_op_t op_q; // Kind of command in flight
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Released count starts full, so a first take is no short recovery
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lo_q <= '0;
      hi_q <= '1;
      op_q <= SWM_OP_RESET;
    end else begin
      lo_q <= line_oe ? lo_q + 32'h1 : '0;
      hi_q <= line_oe ? '0 : hi_q + 32'(hi_q != '1);
      if (cmd_valid && cmd_ready) op_q <= cmd_op;
    end
  end
  a_out_low: assert property (line_out == 1'b0) else $error("line_out high");
  a_idle_release: assert property (cmd_ready |-> !line_oe) else $error("idle drive");
  a_take_pull: assert property (cmd_valid && cmd_ready |=> line_oe) else $error("no pull");
  a_reset_long: assert property ($fell(line_oe) && op_q == SWM_OP_RESET |-> lo_q >= 480 * DIV)
    else $error("reset short");
  a_read_open: assert property ($fell(line_oe) && op_q == SWM_OP_READ |-> lo_q >= DIV && lo_q < 15 * DIV)
    else $error("read low bad");
  a_write_shape: assert property ($fell(line_oe) && op_q == SWM_OP_WRITE |-> lo_q < 15 * DIV || lo_q >= 60 * DIV)
    else $error("write low bad");
  a_slot_recover: assert property ($rose(line_oe) |-> hi_q >= DIV) else $error("no recovery");
  a_valid_pulse: assert property (rsp_valid |-> cmd_ready ##1 !rsp_valid) else $error("valid");
  a_data_hold: assert property ($changed(rsp_data) |=> rsp_valid) else $error("data moved");
  a_pres_hold: assert property (cmd_ready && !cmd_valid |=> $stable(rsp_presence)) else $error("pres");
endmodule // swm_chk
bind swm_master swm_chk #(.DIV(DIV)) u_chk (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_op(cmd_op), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
  .rsp_presence(rsp_presence), .line_out(line_out), .line_oe(line_oe));

//--- testbench/swm_dev.sv
// Purpose: behavioural sensor on the far side of the line
// Assumes: line high unless pulled; DIV cycles per microsecond
// Notes: first byte after presence is a selection code, ignored
`timescale 1ns/1ps
module swm_dev
  import swm_pkg::*;
#(
  parameter int DIV = 4,
  parameter logic [7:0] PAD0 = 8'h5a
) (
  // Clock and enable
  input wire logic clk,
  input wire logic en,
  // Line
  input wire logic line,
  output logic oe = 1'b0
);
  logic [7:0] pad [0:8]; // Scratchpad
  logic [7:0] rx = 8'h00, tx = 8'hff, b; // Shift registers
  logic prv = 1'b1, pres = 1'b0, txm = 1'b0, sl = 1'b0; // Line state
  int lo = 0, t = 0, nb = 0, bc = 0, idx = 0, wp = 0; // Counters
  initial foreach (pad[i]) pad[i] = PAD0 + 8'(i);
  // Slot timing counts from the master's falling edge, presence timing from the reset release
  always @(posedge clk) begin
    prv <= line;
    lo <= line ? 0 : lo + 1;
    t <= t + 1;
    if (!prv && line && lo > 400 * DIV) begin
      {t, nb, bc, wp} <= '0;
      {txm, sl, oe} <= 3'h0;
      pres <= en;
    end else if (pres) begin
      if (t == 30 * DIV) oe <= 1'b1;
      if (t == 150 * DIV) {oe, pres} <= 2'h0;
    end else if (prv && !line) begin
      t <= 0;
      sl <= 1'b1;
      if (txm) oe <= !tx[0];
    end else if (sl && t == 30 * DIV) begin
      sl <= 1'b0;
      oe <= 1'b0;
      bc <= (bc + 1) % 8;
      if (txm) begin
        tx <= (bc == 7 && idx < 8) ? pad[idx + 1] : {1'b1, tx[7:1]};
        idx <= (bc == 7) ? idx + 1 : idx;
      end else begin
        b = {line, rx[7:1]};
        rx <= b;
        if (bc == 7) begin
          nb <= nb + 1;
          if (wp != 0 && nb >= 2 && nb <= 4) pad[wp + nb - 2] <= b;
          if (nb == 1) begin
            case (b)
              CMD_READ_PAD: {txm, tx, idx} <= {1'b1, pad[0], 32'h0};
              CMD_CONVERT, CMD_NVM_RELOAD: {txm, tx} <= {1'b1, 8'hf8};
              CMD_READ_SUPPLY: {txm, tx} <= {1'b1, 8'hff};
              CMD_WRITE_PAD: wp <= 2;
              CMD_WRITE_USER: wp <= 5;
              default: wp <= 0;
            endcase
          end
        end
      end
    end
  end
endmodule // swm_dev

//--- testbench/tb.sv
// Purpose: self-checking bench for the single-wire master
// Assumes: sensor model on a pulled-up line
// Notes: short tick keeps the run brief
`timescale 1ns/1ps
module tb;
  import swm_pkg::*;
  localparam int unsigned DIV = 3; // Cycles per tick, small to keep the run short
  localparam logic [7:0] PAD0 = 8'h5a; // Model's first pad byte
  logic sys_clk, rst, cmd_valid, dev_en, line, d_oe, cmd_ready, rsp_valid, rsp_presence, line_out, line_oe;
  swm_op_t cmd_op;
  logic [3:0] cmd_bits, n;
  logic [7:0] cmd_data, rsp_data, got;
  logic [7:0] ex [0:5];
  logic [7:0] tc [0:3];
  logic [7:0] te [0:3];
  logic [3:0] tn [0:3];
  logic [31:0] rnd;
  int num_errors = 0, tests_run = 0;
  assign line = !(line_oe || d_oe); // Pull-up wins when nobody pulls
  swm_master #(.DIV(DIV)) DUT (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_bits(cmd_bits), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_presence(rsp_presence), .line_in(line), .line_out(line_out), .line_oe(line_oe));
  swm_dev #(.DIV(DIV), .PAD0(PAD0)) u_dev (.clk(sys_clk), .en(dev_en), .line(line), .oe(d_oe));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task results();
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One command, held until taken, then wait for its answer
  task op(input swm_op_t o, input logic [3:0] b, input logic [7:0] d);
    int i;
    i = 0;
    while (cmd_ready !== 1'b1 && i < 9000) begin
      @(negedge sys_clk);
      i++;
    end
    cmd_valid = 1'b1;
    cmd_op = o;
    cmd_bits = b;
    cmd_data = d;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && i < 9000) begin
      @(negedge sys_clk);
      i++;
    end
    if (i >= 9000) begin
      num_errors++;
      results();
    end
    got = rsp_data;
  endtask
  task sel(input logic [7:0] c);
    op(SWM_OP_RESET, 4'h0, 8'h00);
    chk("presence", 8'h01, {7'h0, rsp_presence});
    chk("reset data", 8'h00, got);
    // Slot count above eight means a whole byte
    op(SWM_OP_WRITE, 4'hf, 8'hcc);
    op(SWM_OP_WRITE, 4'h0, c);
  endtask
  initial begin
    {cmd_valid, cmd_bits, cmd_data, dev_en, rst} = {1'b0, 4'h0, 8'h00, 1'b0, 1'b1};
    cmd_op = SWM_OP_RESET;
    rnd = 32'h90f1;
    tc = '{CMD_CONVERT, CMD_NVM_RELOAD, CMD_READ_SUPPLY, CMD_COPY_PAD};
    te = '{8'h08, 8'h08, 8'h01, 8'h03};
    tn = '{4'h4, 4'h4, 4'h1, 4'h2};
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    // Empty line: no presence, data cleared
    op(SWM_OP_RESET, 4'h0, 8'h00);
    chk("no presence", 8'h00, {7'h0, rsp_presence});
    chk("reset data", 8'h00, got);
    dev_en = 1'b1;
    // Threshold then user bytes, random
    for (int k = 0; k < 6; k++) begin
      if (k % 3 == 0) sel(k == 0 ? CMD_WRITE_PAD : CMD_WRITE_USER);
      rnd = xs(rnd);
      ex[k] = rnd[7:0];
      op(SWM_OP_WRITE, 4'h0, ex[k]);
    end
    sel(CMD_READ_PAD);
    for (int j = 0; j < 8; j++) begin
      op(SWM_OP_READ, 4'h0, 8'h00);
      chk("pad", j < 2 ? PAD0 + 8'(j) : ex[j - 2], got);
    end
    // Status and silent commands, short reads right-aligned
    for (int k = 0; k < 4; k++) begin
      sel(tc[k]);
      op(SWM_OP_READ, tn[k], 8'h00);
      chk("status", te[k], got);
    end
    // Random part of byte 0, then cut off by a reset
    sel(CMD_READ_PAD);
    rnd = xs(rnd);
    n = 4'(rnd[2:0]) + 4'h1;
    op(SWM_OP_READ, n, 8'h00);
    chk("partial", PAD0 & 8'((9'h1 << n) - 9'h1), got);
    sel(CMD_READ_SUPPLY);
    op(SWM_OP_READ, 4'h1, 8'h00);
    chk("after abort", 8'h01, got);
    results();
  end
endmodule // tb
